// file: rtl/mrp_regs.vh
`ifndef MRP_REGS_VH
`define MRP_REGS_VH
// read and wrap-setting opcodes
`define MRP_OP_QOUT 8'h6b
`define MRP_OP_DIO 8'hbb
`define MRP_OP_QIO 8'heb
`define MRP_OP_QWD 8'he7
`define MRP_OP_WRAP 8'h77
`define MRP_OP_ID 8'h90
// continuous_read_select_bits value that keeps the mode
`define MRP_CONT_CODE 2'b10
// lines per clock
`define MRP_L1 3'h1
`define MRP_L2 3'h2
`define MRP_L4 3'h4
// rising edges per phase
`define MRP_N_NONE 5'h00
`define MRP_N_ONE 5'h01
`define MRP_N_CMD 5'h08
`define MRP_N_A1 5'h18
`define MRP_N_A2 5'h0c
`define MRP_N_A4 5'h06
`define MRP_N_M1 5'h08
`define MRP_N_M2 5'h04
`define MRP_N_M4 5'h02
`define MRP_N_D_QOUT 5'h08
`define MRP_N_D_QIO 5'h04
`define MRP_N_D_QWD 5'h02
// falling edges per byte, minus one
`define MRP_OC1 3'h7
`define MRP_OC2 3'h3
`define MRP_OC4 3'h1
// wrap_setting_bits = {wrap_length_select, wrap_disable_bit}
`define MRP_WRAP_RST 3'h1
`define MRP_WRAP_BASE 8'hf8
// register byte offsets
`define MRP_OFS_CTRL 8'h00
`define MRP_OFS_STAT 8'h04
`define MRP_OFS_MADDR 8'h08
`define MRP_OFS_MDATA 8'h0c
`define MRP_QE_BIT 0
`endif

// file: rtl/mrp_mem.v
`timescale 1ns/10ps
module mrp_mem #(
   parameter DW = 8,
   parameter AW = 8
) (
   // clock
   input wire clk,
   input wire rst_n,
   input wire ce,
   // write port
   input wire we,
   input wire [AW-1:0] waddr,
   input wire [DW-1:0] wdata,
   // read port
   input wire re,
   input wire [AW-1:0] raddr,
   output reg [DW-1:0] rdata
);
   reg [DW-1:0] arr_q [0:(1<<AW)-1];

   always @(posedge clk)
      if (ce && we)
         arr_q[waddr] <= wdata;

   always @(posedge clk or negedge rst_n)
      if (!rst_n)
         rdata <= {DW{1'b0}};
      else if (ce && re)
         rdata <= arr_q[raddr];
endmodule // mrp_mem

// file: rtl/mrp_fifo.v
`timescale 1ns/10ps
module mrp_fifo #(
   parameter W = 8,
   parameter DEPTH = 8
) (
   // clock
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire flush,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   // depth must be a power of two; pointers carry one extra wrap bit
   localparam AW = $clog2(DEPTH);
   localparam [AW:0] FULL = DEPTH[AW:0];
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW:0] wp_q;
   reg [AW:0] rp_q;
   wire [AW:0] used = wp_q - rp_q;
   wire push = in_valid & in_ready & ce;
   wire pop = out_valid & out_ready & ce;

   assign in_ready = (used != FULL);
   assign out_valid = (used != {(AW+1){1'b0}});
   assign out_data = mem_q[rp_q[AW-1:0]];

   always @(posedge clk)
      if (push)
         mem_q[wp_q[AW-1:0]] <= in_data;

   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end
      else if (ce && flush)
      begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
         if (pop)
            rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
      end
endmodule // mrp_fifo

// file: rtl/mrp_top.v
// Notes on behaviour
// R1: 6B: single-line address, dummy byte, quad out
// R2: any start byte, address steps up per byte
// R3: BB: address and mode dual, data dual
// R4: dual mode bits 10 skip next opcode
// R5: other mode bits restore opcode decoding
// R6: all-ones frame clears continuous read bits
// R7: EB: quad address, mode, four dummies, quad
// R8: quad I/O reads need quad enable bit; the bit is checked only at the opcode, not on continuous reads
// R9: quad read mode bits 10 skip opcode
// R10: E7: even address, two dummy clocks
// R11: word read mode bits 10 skip opcode
// R12: 77: 24 dummy bits then wrap byte
// R13: wrap disable bit, length 8..64 bytes
// R14: wrapped output stays in aligned section
// R15: wrap setting applies to quad I/O reads EB and E7 only, not to 6B
// R16: wrap disable bit set at reset
// R17: 90: address bit zero picks ID order
// R18: output bits change on falling clock edge
// R19: msb first, opcode on one line
`timescale 1ns/10ps
`include "mrp_regs.vh"
module mrp_top #(
   parameter MEM_AW = 8,
   parameter FIFO_DEPTH = 8,
   parameter [7:0] MFR_ID = 8'h5a, // arbitrary value
   parameter [7:0] DEV_ID = 8'h3c // arbitrary value
) (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   input wire ce,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // serial flash pins
   input wire sclk,
   input wire cs_n,
   input wire [3:0] io_i,
   output reg [3:0] io_o,
   output reg [3:0] io_oe
);
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_CMD = 7'h02;
   localparam [6:0] ST_ADDR = 7'h04;
   localparam [6:0] ST_MODE = 7'h08;
   localparam [6:0] ST_DUMMY = 7'h10;
   localparam [6:0] ST_DATA = 7'h20;
   localparam [6:0] ST_IGN = 7'h40;

   // pin synchronisers: {sclk, cs_n, io}
   reg [5:0] s1_q;
   reg [5:0] s2_q;
   reg [5:0] s3_q;
   wire csn_n = s2_q[4];
   wire [3:0] io_s = s2_q[3:0];
   wire rise = s2_q[5] & ~s3_q[5];
   wire fall = ~s2_q[5] & s3_q[5];

   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         s1_q <= 6'h10;
         s2_q <= 6'h10;
         s3_q <= 6'h10;
      end
      else if (ce)
      begin
         s1_q <= {sclk, cs_n, io_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end

   // sequencer state
   reg [6:0] st_q;
   reg [7:0] cmd_q;
   reg [4:0] cnt_q;
   reg [23:0] sh_in_q;
   reg [23:0] fetch_addr_q;
   reg fetch_on_q;
   reg pend_q;
   reg id_sel_q;
   reg cont_q;
   reg [7:0] cont_cmd_q;
   reg ones_q;
   reg rose_q;
   reg [2:0] wrap_setting_bits_q;
   reg [7:0] sh_out_q;
   reg [2:0] ocnt_q;
   reg quad_lines_enable_bit_q;

   // command decode; while the opcode shifts in, look at the byte being completed
   reg [23:0] nxt_in;
   wire [7:0] cmd_w = (st_q == ST_CMD) ? nxt_in[7:0] : cmd_q;
   reg cfg_ok;
   reg [2:0] in_l;
   reg [2:0] out_l;
   reg [4:0] n_a;
   reg [4:0] n_m;
   reg [4:0] n_d;

   always @*
   begin
      cfg_ok = 1'b0;
      in_l = `MRP_L1;
      out_l = `MRP_L1;
      n_a = `MRP_N_A1;
      n_m = `MRP_N_NONE;
      n_d = `MRP_N_NONE;
      case (cmd_w)
         `MRP_OP_QOUT:
         begin
            cfg_ok = 1'b1;
            out_l = `MRP_L4; // R1
            n_d = `MRP_N_D_QOUT; // R1
         end
         `MRP_OP_DIO:
         begin
            cfg_ok = 1'b1;
            in_l = `MRP_L2; // R3
            out_l = `MRP_L2; // R3
            n_a = `MRP_N_A2;
            n_m = `MRP_N_M2;
         end
         `MRP_OP_QIO:
         begin
            cfg_ok = quad_lines_enable_bit_q; // R8
            in_l = `MRP_L4; // R7
            out_l = `MRP_L4;
            n_a = `MRP_N_A4;
            n_m = `MRP_N_M4;
            n_d = `MRP_N_D_QIO; // R7
         end
         `MRP_OP_QWD:
         begin
            cfg_ok = quad_lines_enable_bit_q; // R8
            in_l = `MRP_L4;
            out_l = `MRP_L4;
            n_a = `MRP_N_A4;
            n_m = `MRP_N_M4;
            n_d = `MRP_N_D_QWD; // R10
         end
         `MRP_OP_WRAP:
         begin
            cfg_ok = 1'b1;
            n_m = `MRP_N_M1; // R12
         end
         `MRP_OP_ID:
            cfg_ok = 1'b1; // R17
         default:
            cfg_ok = 1'b0;
      endcase
   end

   // input shifter, msb first on the highest used line
   wire [2:0] lines_now = (st_q == ST_CMD) ? `MRP_L1 : in_l; // R19
   always @*
   begin
      case (lines_now)
         `MRP_L2: nxt_in = {sh_in_q[21:0], io_s[1:0]};
         `MRP_L4: nxt_in = {sh_in_q[19:0], io_s};
         default: nxt_in = {sh_in_q[22:0], io_s[0]}; // R19
      endcase
   end
   wire [4:0] cnt_inc = cnt_q + `MRP_N_ONE;

   // prefetch address step with optional wrap inside the page
   wire wrap_on = ~wrap_setting_bits_q[0] & ((cmd_q == `MRP_OP_QIO) | (cmd_q == `MRP_OP_QWD)); // R13 R15
   wire [7:0] wmask = ~(`MRP_WRAP_BASE << wrap_setting_bits_q[2:1]); // R13
   wire [7:0] lo_inc = fetch_addr_q[7:0] + 8'h01;
   wire [23:0] fetch_next = wrap_on ?
      {fetch_addr_q[23:8], (fetch_addr_q[7:0] & ~wmask) | (lo_inc & wmask)} : // R14
      fetch_addr_q + 24'h000001; // R2

   // fifo and array
   wire f_in_ready;
   wire f_out_valid;
   wire [7:0] f_out_data;
   wire [7:0] m_rdata;
   wire rd_en = fetch_on_q & ~pend_q & f_in_ready & ~csn_n;
   wire is_id = (cmd_q == `MRP_OP_ID);
   wire pop = fall & (st_q == ST_DATA) & (ocnt_q == 3'h0) & ~is_id;
   wire mem_we;
   reg [MEM_AW-1:0] ptr_q;

   mrp_fifo #(
      .W(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .ce(ce),
      .flush(csn_n),
      .in_valid(pend_q),
      .in_ready(f_in_ready),
      .in_data(m_rdata),
      .out_valid(f_out_valid),
      .out_ready(pop),
      .out_data(f_out_data)
   );

   mrp_mem #(
      .DW(8),
      .AW(MEM_AW)
   ) u_mem (
      .clk(hclk),
      .rst_n(hresetn),
      .ce(ce),
      .we(mem_we),
      .waddr(ptr_q),
      .wdata(hwdata[7:0]),
      .re(rd_en),
      .raddr(fetch_addr_q[MEM_AW-1:0]),
      .rdata(m_rdata)
   );

   // output serialiser; an empty fifo sends zeros rather than stalling the host
   wire [7:0] byte_new = is_id ? (id_sel_q ? DEV_ID : MFR_ID) : (f_out_valid ? f_out_data : 8'h00); // R17
   wire [7:0] src = (ocnt_q == 3'h0) ? byte_new : sh_out_q;
   reg [3:0] io_o_d;
   reg [3:0] io_oe_d;
   reg [7:0] sh_out_d;
   reg [2:0] oc_init;
   always @*
   begin
      case (out_l)
         `MRP_L4:
         begin
            io_o_d = src[7:4]; // R19
            io_oe_d = 4'hf;
            sh_out_d = {src[3:0], 4'h0};
            oc_init = `MRP_OC4;
         end
         `MRP_L2:
         begin
            io_o_d = {2'b00, src[7:6]};
            io_oe_d = 4'h3;
            sh_out_d = {src[5:0], 2'b00};
            oc_init = `MRP_OC2;
         end
         default:
         begin
            io_o_d = {2'b00, src[7], 1'b0};
            io_oe_d = 4'h2;
            sh_out_d = {src[6:0], 1'b0};
            oc_init = `MRP_OC1;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         st_q <= ST_IDLE;
         cmd_q <= 8'h00;
         cnt_q <= `MRP_N_NONE;
         sh_in_q <= 24'h000000;
         fetch_addr_q <= 24'h000000;
         fetch_on_q <= 1'b0;
         pend_q <= 1'b0;
         id_sel_q <= 1'b0;
         cont_q <= 1'b0;
         cont_cmd_q <= 8'h00;
         ones_q <= 1'b0;
         rose_q <= 1'b0;
         wrap_setting_bits_q <= `MRP_WRAP_RST; // R16
         sh_out_q <= 8'h00;
         ocnt_q <= 3'h0;
         io_o <= 4'h0;
         io_oe <= 4'h0;
      end
      else if (ce)
      begin
         if (rd_en)
         begin
            fetch_addr_q <= fetch_next; // R2
            pend_q <= 1'b1;
         end
         else if (pend_q && f_in_ready)
            pend_q <= 1'b0;
         if (csn_n)
         begin
            // frame ends: release the lines and drop the prefetch
            st_q <= ST_IDLE;
            io_oe <= 4'h0;
            fetch_on_q <= 1'b0;
            pend_q <= 1'b0;
            if (st_q != ST_IDLE && ones_q && rose_q && st_q != ST_DATA)
               cont_q <= 1'b0; // R6
         end
         else if (st_q == ST_IDLE)
         begin
            st_q <= cont_q ? ST_ADDR : ST_CMD; // R4 R9 R11
            if (cont_q)
               cmd_q <= cont_cmd_q;
            cnt_q <= `MRP_N_NONE;
            ones_q <= 1'b1;
            rose_q <= 1'b0;
            ocnt_q <= 3'h0;
         end
         else
         begin
            if (rise && st_q != ST_DATA)
            begin
               sh_in_q <= nxt_in;
               cnt_q <= cnt_inc;
               rose_q <= 1'b1;
               ones_q <= ones_q & (&io_s);
               case (st_q)
                  ST_CMD:
                     if (cnt_inc == `MRP_N_CMD)
                     begin
                        cmd_q <= nxt_in[7:0]; // R19
                        cnt_q <= `MRP_N_NONE;
                        st_q <= cfg_ok ? ST_ADDR : ST_IGN; // R8
                     end
                  ST_ADDR:
                     if (cnt_inc == n_a)
                     begin
                        fetch_addr_q <= nxt_in; // R2
                        fetch_on_q <= ~is_id & (cmd_q != `MRP_OP_WRAP);
                        id_sel_q <= nxt_in[0]; // R17
                        cnt_q <= `MRP_N_NONE;
                        if (n_m != `MRP_N_NONE)
                           st_q <= ST_MODE;
                        else if (n_d != `MRP_N_NONE)
                           st_q <= ST_DUMMY;
                        else
                           st_q <= ST_DATA;
                     end
                  ST_MODE:
                     if (cnt_inc == n_m)
                     begin
                        cnt_q <= `MRP_N_NONE;
                        if (cmd_q == `MRP_OP_WRAP)
                        begin
                           wrap_setting_bits_q <= nxt_in[6:4]; // R12 R15
                           st_q <= ST_IGN;
                        end
                        else
                        begin
                           cont_q <= (nxt_in[5:4] == `MRP_CONT_CODE); // R4 R5 R9 R11
                           cont_cmd_q <= cmd_q;
                           st_q <= (n_d != `MRP_N_NONE) ? ST_DUMMY : ST_DATA;
                        end
                     end
                  ST_DUMMY:
                     if (cnt_inc == n_d)
                     begin
                        cnt_q <= `MRP_N_NONE;
                        st_q <= ST_DATA;
                     end
                  default:
                     cnt_q <= cnt_q;
               endcase
            end
            if (fall && st_q == ST_DATA)
            begin
               io_o <= io_o_d; // R18
               io_oe <= io_oe_d;
               sh_out_q <= sh_out_d;
               ocnt_q <= (ocnt_q == 3'h0) ? oc_init : ocnt_q - 3'h1;
               if (ocnt_q == 3'h0)
                  id_sel_q <= ~id_sel_q; // R17
            end
         end
      end

   // ahb-lite slave: writes take no wait state, reads take one
   wire ahb_go = hsel & hready & htrans[1] & ce;
   reg wr_q;
   reg rd_q;
   reg [7:0] ofs_q;
   wire wr_do = wr_q & hready & ce;
   assign mem_we = wr_do & (ofs_q == `MRP_OFS_MDATA);
   assign hreadyout = ~rd_q;
   assign hresp = 1'b0;

   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ofs_q <= 8'h00;
         hrdata <= 32'h00000000;
         ptr_q <= {MEM_AW{1'b0}};
         quad_lines_enable_bit_q <= 1'b0;
      end
      else if (ce)
      begin
         if (ahb_go)
         begin
            wr_q <= hwrite;
            rd_q <= ~hwrite;
            ofs_q <= haddr[7:0];
         end
         else
         begin
            if (hready)
               wr_q <= 1'b0;
            rd_q <= 1'b0;
         end
         if (rd_q)
         begin
            case (ofs_q)
               `MRP_OFS_CTRL: hrdata <= {31'h00000000, quad_lines_enable_bit_q};
               `MRP_OFS_STAT: hrdata <= {9'h000, st_q, cont_cmd_q, 4'h0, cont_q, wrap_setting_bits_q};
               `MRP_OFS_MADDR: hrdata <= {{(32-MEM_AW){1'b0}}, ptr_q};
               default: hrdata <= 32'h00000000;
            endcase
         end
         if (wr_do)
         begin
            if (ofs_q == `MRP_OFS_CTRL)
               quad_lines_enable_bit_q <= hwdata[`MRP_QE_BIT];
            if (ofs_q == `MRP_OFS_MADDR)
               ptr_q <= hwdata[MEM_AW-1:0];
            if (mem_we)
               ptr_q <= ptr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
         end
      end
endmodule // mrp_top

// file: verif/mrp_top_properties.sv
`timescale 1ns/10ps
module mrp_top_properties (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   input wire ce,
   // ahb-lite
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // serial pins
   input wire sclk,
   input wire cs_n,
   input wire [3:0] io_i,
   input wire [3:0] io_o,
   input wire [3:0] io_oe
);
   logic [7:0] sel_cnt_q;
   logic [7:0] sel_cnt_d;
   default clocking dc @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // saturates so a long frame never looks like a fresh one
   assign sel_cnt_d = cs_n ? 8'h00 : (sel_cnt_q == 8'hff ? sel_cnt_q : sel_cnt_q + 8'h01);
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         sel_cnt_q <= 8'h00;
      else
         sel_cnt_q <= sel_cnt_d;
   sequence rd_req;
      hsel && hready && htrans[1] && !hwrite && ce;
   endsequence
   sequence rd_ans;
      !hreadyout ##1 hreadyout;
   endsequence
   resp_okay_a:
      assert property (hresp == 1'b0) else $error("hresp not okay");
   read_wait_a:
      assert property (rd_req |=> rd_ans) else $error("read wait state wrong");
   write_fast_a:
      assert property (hsel && hready && htrans[1] && hwrite && ce |=> hreadyout) else $error("write stalled");
   hrdata_hold_a:
      assert property ($changed(hrdata) |-> $past(!hreadyout)) else $error("hrdata changed outside read");
   opcode_quiet_a:
      assert property (!cs_n && sel_cnt_q < 8'd100 |-> io_oe == 4'h0) else $error("early drive");
   idle_release_a:
      assert property (cs_n [*8] |-> io_oe == 4'h0) else $error("drive while deselected");
   fall_launch_a:
      assert property (io_oe != 4'h0 && $changed(io_o) |-> !sclk && $past(!sclk, 2)) else $error("data not on fall");
   high_stable_a:
      assert property (sclk [*5] |-> $stable(io_o) && $stable(io_oe)) else $error("data moved while sclk high");
   lane_group_a:
      assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad lane group");
endmodule // mrp_top_properties
bind mrp_top mrp_top_properties u_chk (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe)
);

// file: verif/mrp_host.sv
`timescale 1ns/10ps
module mrp_host (
   // serial link
   output logic sclk,
   output logic cs_n,
   output logic [3:0] io_i,
   // device drive
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe
);
   logic drv;
   logic oe_seen;
   logic [3:0] hv;
   logic [7:0] rx [0:7];
   // a released line shows the inverse of the host level, never a stale copy
   assign io_i = drv ? hv : (io_oe & io_o) | (~io_oe & ~hv);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      drv = 1'b0;
      hv = 4'hf;
      oe_seen = 1'b0;
   end
   always @(io_oe)
      if (io_oe != 4'h0)
         oe_seen = 1'b1;
   task automatic shift(input logic [31:0] v, input int nb, input int ln);
      v = v << (32 - nb);
      drv = 1'b1;
      for (int k = 0; k < nb / ln; k++)
      begin
         hv = 4'hf;
         for (int j = 0; j < ln; j++)
            hv[ln - 1 - j] = v[31 - j];
         v = v << ln;
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
   endtask
   task automatic recv(input int ln, input int nb);
      logic [7:0] b;
      drv = 1'b0;
      for (int n = 0; n < nb; n++)
      begin
         for (int k = 0; k < 8 / ln; k++)
         begin
            #80 sclk = 1'b1;
            b = ln == 1 ? {b[6:0], io_i[1]} : ln == 2 ? {b[5:0], io_i[1:0]} : {b[3:0], io_i};
            #80 sclk = 1'b0;
         end
         rx[n] = b;
      end
   endtask
   task automatic frame(input logic [7:0] op, input logic wo, input logic [23:0] a, input int al,
      input logic [7:0] md, input int nd, input int dl, input int nb);
      #3 cs_n = 1'b0;
      #40;
      if (wo)
         shift({24'h0, op}, 8, 1);
      shift({8'h0, a}, 24, al);
      if (al > 1 || nb == 0)
         shift({24'h0, md}, 8, al);
      shift(32'h0, nd * al, al);
      recv(dl, nb);
      #40 cs_n = 1'b1;
      #200;
   endtask
   // all lines high for a few clocks, ending before any data phase, so continuous read is dropped
   task automatic burst(input int nc);
      #3 cs_n = 1'b0;
      #40;
      shift(32'hffffffff, nc * 4, 4);
      #40 cs_n = 1'b1;
      #200;
   endtask
endmodule // mrp_host

// file: verif/mrp_top_test.sv
`timescale 1ns/10ps
`define CHK(n, e, s) \
begin \
   compares++; \
   if ((s) !== (e)) \
   begin \
      fails++; \
      $display("MISMATCH %s expected %h seen %h", n, e, s); \
   end \
end
module mrp_top_test;
   localparam logic [7:0] MFR = 8'h5a; // arbitrary value
   localparam logic [7:0] DEV = 8'h3c; // arbitrary value
   logic hclk;
   logic hresetn;
   logic hsel;
   logic hwrite;
   logic ce;
   logic [1:0] htrans;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] d;
   wire [31:0] hrdata;
   wire hreadyout;
   wire hresp;
   wire sclk;
   wire cs_n;
   wire [3:0] io_i;
   wire [3:0] io_o;
   wire [3:0] io_oe;
   int fails = 0;
   int compares = 0;
   mrp_top #(.MFR_ID(MFR), .DEV_ID(DEV)) u_dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
   mrp_host u_host (.sclk(sclk), .cs_n(cs_n), .io_i(io_i), .io_o(io_o), .io_oe(io_oe));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   function automatic logic [7:0] ex(input logic [23:0] a, input int i, input int wl);
      logic [7:0] x;
      x = wl == 0 ? a[7:0] + i[7:0] : (a[7:0] & ~(wl[7:0] - 8'h01)) | ((a[7:0] + i[7:0]) & (wl[7:0] - 8'h01));
      return x * 8'h07 + 8'h03;
   endfunction
   task automatic wt(output logic [31:0] r);
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 64)
      begin
         n++;
         @(negedge hclk);
      end
      if (n == 64)
         fails++;
      r = hrdata;
      @(posedge hclk);
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wt(d);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wt(d);
   endtask
   task automatic rdc(input logic [7:0] op, input logic wo, input logic [23:0] a, input int al,
      input logic [7:0] md, input int nd, input int dl, input int wl);
      u_host.frame(op, wo, a, al, md, nd, dl, 4);
      for (int i = 0; i < 4; i++)
         `CHK("data", ex(a, i, wl), u_host.rx[i])
   endtask
   task automatic t_regs;
      ahb(1'b0, 32'h0, 32'h0);
      `CHK("ctrl", 32'h0, d)
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("stat", 32'h0001_0001, d)
      ahb(1'b1, 32'h10, 32'hffff_ffff);
      ahb(1'b0, 32'h10, 32'h0);
      `CHK("unmapped", 32'h0, d)
      // a write while the clock enable is low must leave the quad enable bit clear
      ce <= 1'b0;
      ahb(1'b1, 32'h0, 32'h1);
      ce <= 1'b1;
      ahb(1'b0, 32'h0, 32'h0);
      `CHK("frozen", 32'h0, d)
      ahb(1'b1, 32'h8, 32'h0);
      for (int i = 0; i < 256; i++)
         ahb(1'b1, 32'hc, {24'h0, ex(i[23:0], 0, 0)});
      $display("regs done");
   endtask
   task automatic t_lines;
      rdc(8'h6b, 1'b1, 24'h0000fe, 1, 8'h00, 8, 4, 0);
      rdc(8'hbb, 1'b1, 24'h000123, 2, 8'h20, 0, 2, 0);
      rdc(8'h00, 1'b0, 24'h000040, 2, 8'h00, 0, 2, 0);
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("cont", 1'b0, d[3])
      rdc(8'hbb, 1'b1, 24'h0000f0, 2, 8'h00, 0, 2, 0);
      u_host.oe_seen = 1'b0;
      u_host.frame(8'heb, 1'b1, 24'h10, 4, 8'h00, 4, 4, 2);
      `CHK("refused", 1'b0, u_host.oe_seen)
      ahb(1'b1, 32'h0, 32'h1);
      rdc(8'heb, 1'b1, 24'h000031, 4, 8'h20, 4, 4, 0);
      rdc(8'h00, 1'b0, 24'h000077, 4, 8'h20, 4, 4, 0);
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("cont", 1'b1, d[3])
      u_host.burst(4);
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("cont", 1'b0, d[3])
      rdc(8'he7, 1'b1, 24'h000052, 4, 8'h20, 2, 4, 0);
      rdc(8'h00, 1'b0, 24'h0000a4, 4, 8'hf0, 2, 4, 0);
      ahb(1'b0, 32'h4, 32'h0);
      `CHK("cont", 1'b0, d[3])
      $display("lines done");
   endtask
   task automatic t_wrap;
      for (int c = 0; c < 4; c++)
      begin
         u_host.frame(8'h77, 1'b1, 24'h0, 1, {1'b0, c[1:0], 5'h00}, 0, 1, 0);
         ahb(1'b0, 32'h4, 32'h0);
         `CHK("wrap", {c[1:0], 1'b0}, d[2:0])
         rdc(c[0] ? 8'he7 : 8'heb, 1'b1, {16'h0, 8'h3e + (8'h08 << c)}, 4, 8'h00, c[0] ? 2 : 4, 4, 8 << c);
      end
      u_host.frame(8'h77, 1'b1, 24'h0, 1, 8'h10, 0, 1, 0);
      rdc(8'heb, 1'b1, 24'h00003e, 4, 8'h00, 4, 4, 0);
      $display("wrap done");
   endtask
   task automatic t_id;
      u_host.frame(8'h90, 1'b1, 24'h0, 1, 8'h00, 0, 1, 3);
      `CHK("id0", MFR, u_host.rx[0])
      `CHK("id1", DEV, u_host.rx[1])
      `CHK("id2", MFR, u_host.rx[2])
      u_host.frame(8'h90, 1'b1, 24'h1, 1, 8'h00, 0, 1, 2);
      `CHK("id3", DEV, u_host.rx[0])
      `CHK("id4", MFR, u_host.rx[1])
      $display("id done");
   endtask
   task automatic summarize;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ce = 1'b1;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_regs;
      t_lines;
      t_wrap;
      t_id;
      summarize;
   end
   initial
   begin
      #600000;
      fails++;
      summarize;
   end
endmodule // mrp_top_test
